// ===== hdl/dac_dram_ctrl.sv
// Purpose: dram space settings, access sequencing and refresh control
// Assumes: acc.req held until accAck; refreshTrigger from the refresh timer
// Notes: registers survive manualResetn; only resetn clears them
`timescale 1ns/10ps
// Notes on behaviour
// - dram area settings act only with dram space enabled, refresh settings always
// - power-on clears both registers, manual keeps
// - wide access: dual column or dual write
// - narrow access uses lower strobes only
// - row strobe held low or raised between accesses
// - precharge lasts one or two states
// - burst mode skips row on row match
// - column strobe high duty 50 or 35
// - address multiplexing on or off
// - row shift 8, 9 or 10 bits
// - shift code sets compared row range
// - refresh disabled means no refresh
// - kind bit picks cbr or self-refresh
// - cbr waits 1 to 4 states, pin ignored
// - wait enable low means no cbr waits
// - timer match starts cbr refresh
module dac_dram_ctrl
   import dac_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   input wire logic manualResetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // system settings and events
   input wire logic dramSpaceEnable,
   input wire logic refreshWaitEnable,
   input wire logic refreshTrigger,
   input wire logic nonDramAccess,
   // access request
   input dac_acc_type acc,
   output logic accAck,
   output logic accDone,
   // dram pins
   input wire logic waitN,
   output dac_pins_type pins,
   output logic selfRefreshOn
);
   dac_state_type r;
   dac_state_type n;
   logic [15:0] eff;
   logic [3:0] sh;
   logic rfshOn;
   logic selfKind;
   logic rfshWant;
   logic [1:0] rfshWaitCode;
   logic hit;
   logic dramOk;
   logic wrAcc;
   logic run;
   logic stateEnd;
   logic [DAC_CNT_W-1:0] phase;
   logic [DAC_CNT_W-1:0] dutyH;
   logic casWin;
   logic unmapped;

   dac_state_timer #(
      .TICKS(DAC_STATE_TICKS)
   ) u_timer (
      .mclk(mclk),
      .resetn(resetn),
      .run(run),
      .phase(phase),
      .stateEnd(stateEnd)
   );

   ////////////////////////////////////////////////////////////////////
   // decode of settings

   always_comb
   begin
      eff = dramSpaceEnable ? r.dramCtrl : 16'h0000;
      dramOk = dramSpaceEnable && r.mrstSync;
      // shift code, reserved code treated as ten
      case (eff[DAC_SHIFT+:2])
         2'b00: sh = 4'h8;
         2'b01: sh = 4'h9;
         default: sh = 4'ha;
      endcase
      rfshOn = r.rfshCtrl[DAC_RFEN];
      selfKind = r.rfshCtrl[DAC_RFKIND];
      rfshWaitCode = r.rfshCtrl[DAC_RFWAIT+:2];
      rfshWant = rfshOn && (selfKind || r.rfshPend);
      hit = eff[DAC_BURST] && r.rowValid && ((acc.addr >> sh) == (r.lastRow >> sh));
      dutyH = eff[DAC_DUTY35] ? DAC_HIGH35 : DAC_HIGH50;
      run = !(r.seq inside {SQ_IDLE, SQ_HOLD, SQ_SELF});
      wrAcc = psel && penable && pwrite;
      unmapped = !(paddr inside {DAC_OFF_DRAM, DAC_OFF_RFSH, DAC_OFF_STAT});
   end

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      n = r;
      accAck = 1'b0;
      n.done = 1'b0;
      // pins are sampled here, two flops before use
      n.mrstMeta = manualResetn;
      n.mrstSync = r.mrstMeta;
      n.waitMeta = waitN;
      n.waitSync = r.waitMeta;
      if (psel && !penable)
      begin
         case (paddr)
            DAC_OFF_DRAM: n.rdData = r.dramCtrl;
            DAC_OFF_RFSH: n.rdData = r.rfshCtrl;
            DAC_OFF_STAT: n.rdData = {9'h000, r.selfOn, r.rfshPend, r.rowValid, r.seq};
            default: n.rdData = 16'h0000;
         endcase
      end
      if (wrAcc && paddr == DAC_OFF_DRAM && pstrb[1])
      begin
         n.dramCtrl = pwdata[15:0] & DAC_DRAM_WMASK;
      end
      if (wrAcc && paddr == DAC_OFF_RFSH && pstrb[1:0] == 2'b11 &&
          pwdata[15:8] == DAC_RFSH_KEY)
      begin
         n.rfshCtrl = pwdata[15:0] & DAC_RFSH_WMASK;
      end
      if (!(rfshOn && !selfKind))
      begin
         n.rfshPend = 1'b0;
      end
      case (r.seq)
         SQ_IDLE:
         begin
            if (rfshWant)
            begin
               n.seq = SQ_CBR_CAS;
               n.selfOn = selfKind;
               n.rfshPend = 1'b0;
               n.rowValid = 1'b0;
            end
            else if (acc.req && dramOk)
            begin
               accAck = 1'b1;
               n.cur = acc;
               n.seq = SQ_ROW;
            end
         end
         SQ_ROW:
         begin
            if (stateEnd)
            begin
               n.seq = SQ_COL;
            end
         end
         SQ_COL:
         begin
            // wait pin extends the column state
            if (stateEnd && r.waitSync)
            begin
               n.done = 1'b1;
               n.lastRow = r.cur.addr;
               n.rowValid = 1'b1;
               if (rfshWant || !dramOk)
               begin
                  n.seq = SQ_PRECH;
                  n.prechLeft = eff[DAC_PRECH2];
               end
               else if (acc.req && eff[DAC_BURST] &&
                        (acc.addr >> sh) == (r.cur.addr >> sh))
               begin
                  accAck = 1'b1;
                  n.cur = acc;
                  n.seq = SQ_COL;
               end
               else if (eff[DAC_HOLDLOW])
               begin
                  n.seq = SQ_HOLD;
               end
               else
               begin
                  n.seq = SQ_PRECH;
                  n.prechLeft = eff[DAC_PRECH2];
               end
            end
         end
         SQ_HOLD:
         begin
            if (rfshWant || !dramOk || (acc.req && !hit))
            begin
               n.seq = SQ_PRECH;
               n.prechLeft = eff[DAC_PRECH2];
            end
            else if (acc.req)
            begin
               accAck = 1'b1;
               n.cur = acc;
               n.seq = SQ_COL;
            end
         end
         SQ_PRECH:
         begin
            if (stateEnd)
            begin
               if (r.prechLeft)
               begin
                  n.prechLeft = 1'b0;
               end
               else
               begin
                  n.seq = SQ_IDLE;
               end
            end
         end
         SQ_CBR_CAS:
         begin
            if (stateEnd)
            begin
               n.seq = SQ_CBR_RAS;
               n.waitLeft = refreshWaitEnable ? {1'b0, rfshWaitCode} + 3'h1 : 3'h0;
            end
         end
         SQ_CBR_RAS:
         begin
            if (stateEnd)
            begin
               if (r.selfOn)
               begin
                  n.seq = SQ_SELF;
               end
               else if (r.waitLeft != 3'h0)
               begin
                  n.seq = SQ_CBR_WAIT;
               end
               else
               begin
                  n.seq = SQ_PRECH;
                  n.prechLeft = eff[DAC_PRECH2];
               end
            end
         end
         SQ_CBR_WAIT:
         begin
            if (stateEnd)
            begin
               n.waitLeft = r.waitLeft - 3'h1;
               if (r.waitLeft == 3'h1)
               begin
                  n.seq = SQ_PRECH;
                  n.prechLeft = eff[DAC_PRECH2];
               end
            end
         end
         SQ_SELF:
         begin
            if (!(rfshOn && selfKind))
            begin
               n.selfOn = 1'b0;
               n.seq = SQ_PRECH;
               n.prechLeft = eff[DAC_PRECH2];
            end
         end
         default: n.seq = SQ_IDLE;
      endcase
      if (refreshTrigger && rfshOn && !selfKind)
      begin
         n.rfshPend = 1'b1;
      end
      if (nonDramAccess)
      begin
         n.rowValid = 1'b0;
      end
      if (!r.mrstSync)
      begin
         n.seq = SQ_IDLE;
         n.rowValid = 1'b0;
         n.rfshPend = 1'b0;
         n.selfOn = 1'b0;
         accAck = 1'b0;
      end
      // pins, one clock behind the sequencer
      casWin = (r.seq == SQ_COL && phase >= dutyH) ||
               (r.seq inside {SQ_CBR_CAS, SQ_CBR_RAS, SQ_CBR_WAIT, SQ_SELF});
      n.pins = DAC_PINS_IDLE;
      // row strobe low while row open
      n.pins.rasN = !(r.seq inside {SQ_ROW, SQ_COL, SQ_HOLD, SQ_CBR_RAS,
                                    SQ_CBR_WAIT, SQ_SELF});
      n.pins.addr = (r.seq == SQ_ROW && eff[DAC_MUXEN]) ? (r.cur.addr >> sh) : r.cur.addr;
      if (r.seq == SQ_COL && r.cur.wide && !eff[DAC_DUALWE])
      begin
         n.pins.upperColN = !(casWin && r.cur.hiByte);
         n.pins.lowerColN = !(casWin && r.cur.loByte);
         n.pins.lowerWrN = !r.cur.write;
      end
      else if (r.seq == SQ_COL && r.cur.wide)
      begin
         n.pins.lowerColN = !casWin;
         n.pins.upperWrN = !(r.cur.write && r.cur.hiByte);
         n.pins.lowerWrN = !(r.cur.write && r.cur.loByte);
      end
      else if (r.seq == SQ_COL)
      begin
         n.pins.lowerColN = !casWin;
         n.pins.lowerWrN = !r.cur.write;
      end
      else
      begin
         n.pins.lowerColN = !casWin;
         n.pins.upperColN = !(casWin && !eff[DAC_DUALWE]);
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         r <= '0;
         r.dramCtrl <= DAC_DRAM_RST;
         r.rfshCtrl <= DAC_RFSH_RST;
         r.pins <= DAC_PINS_IDLE;
      end
      else
      begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   assign prdata = {16'h0000, r.rdData};
   assign pready = 1'b1;
   assign pslverr = psel && penable && unmapped;
   assign pins = r.pins;
   assign accDone = r.done;
   assign selfRefreshOn = r.selfOn;

   ////////////////////////////////////////////////////////////////////
   // checks

   logic [6:0] prechRun;
   localparam int PRE1 = DAC_STATE_TICKS;
   localparam int PRE2 = 2 * DAC_STATE_TICKS;

   always_ff @(posedge mclk)
   begin
      if (!resetn || r.seq != SQ_PRECH)
      begin
         prechRun <= 7'h00;
      end
      else
      begin
         prechRun <= prechRun + 7'h01;
      end
   end

   property p_keep;
      @(posedge mclk) disable iff (!resetn)
      (!r.mrstSync && !wrAcc) |=> ($stable(r.dramCtrl) && $stable(r.rfshCtrl));
   endproperty
   a_keep: assert property (p_keep) else $error("registers lost in manual reset");

   property p_gate;
      @(posedge mclk) disable iff (!resetn || !r.mrstSync)
      !dramSpaceEnable |-> !accAck;
   endproperty
   a_gate: assert property (p_gate) else $error("access taken with dram space off");

   property p_key;
      @(posedge mclk) disable iff (!resetn)
      (wrAcc && paddr == DAC_OFF_RFSH && pwdata[15:8] != DAC_RFSH_KEY) |=> $stable(r.rfshCtrl);
   endproperty
   a_key: assert property (p_key) else $error("refresh register took unkeyed write");

   property p_hold;
      @(posedge mclk) disable iff (!resetn || !r.mrstSync)
      (r.seq == SQ_HOLD) |=> !pins.rasN;
   endproperty
   a_hold: assert property (p_hold) else $error("row strobe not held low");

   property p_prech;
      @(posedge mclk) disable iff (!resetn || !r.mrstSync)
      (r.seq == SQ_PRECH && n.seq == SQ_IDLE) |->
         (int'(prechRun) + 1 == (eff[DAC_PRECH2] ? PRE2 : PRE1));
   endproperty
   a_prech: assert property (p_prech) else $error("precharge length wrong");

   property p_burst;
      @(posedge mclk) disable iff (!resetn || !r.mrstSync)
      (r.seq == SQ_HOLD && n.seq == SQ_COL) |-> eff[DAC_BURST];
   endproperty
   a_burst: assert property (p_burst) else $error("row skipped outside burst");

   property p_duty;
      @(posedge mclk) disable iff (!resetn || !r.mrstSync)
      (r.seq == SQ_COL && phase < dutyH) |=> pins.lowerColN;
   endproperty
   a_duty: assert property (p_duty) else $error("column strobe low too early");

   property p_mux;
      @(posedge mclk) disable iff (!resetn || !r.mrstSync)
      (r.seq == SQ_ROW && eff[DAC_MUXEN] && eff[DAC_SHIFT+:2] == 2'b01)
         |=> pins.addr == ($past(r.cur.addr) >> 9);
   endproperty
   a_mux: assert property (p_mux) else $error("row address shift wrong");

   property p_narrow;
      @(posedge mclk) disable iff (!resetn || !r.mrstSync)
      (r.seq == SQ_COL && !r.cur.wide) |=> (pins.upperColN && pins.upperWrN);
   endproperty
   a_narrow: assert property (p_narrow) else $error("upper strobe on narrow access");

   property p_dualwe;
      @(posedge mclk) disable iff (!resetn || !r.mrstSync)
      (r.seq == SQ_COL && r.cur.wide && eff[DAC_DUALWE]) |=> pins.upperColN;
   endproperty
   a_dualwe: assert property (p_dualwe) else $error("upper column strobe in dual write");

   property p_wait;
      @(posedge mclk) disable iff (!resetn || !r.mrstSync)
      (r.seq == SQ_CBR_CAS && stateEnd && refreshWaitEnable)
         |=> r.waitLeft == {1'b0, $past(rfshWaitCode)} + 3'h1;
   endproperty
   a_wait: assert property (p_wait) else $error("cbr wait count wrong");

   property p_nowait;
      @(posedge mclk) disable iff (!resetn || !r.mrstSync)
      (r.seq == SQ_CBR_CAS && stateEnd && !refreshWaitEnable && !r.selfOn)
         |=> ##20 r.seq == SQ_PRECH;
   endproperty
   a_nowait: assert property (p_nowait) else $error("cbr waits without enable");

   property p_self;
      @(posedge mclk) disable iff (!resetn || !r.mrstSync)
      (r.seq == SQ_IDLE && rfshOn && selfKind) |=> r.seq == SQ_CBR_CAS ##[40:41] r.seq == SQ_SELF;
   endproperty
   a_self: assert property (p_self) else $error("self-refresh not entered");

   property p_trig;
      @(posedge mclk) disable iff (!resetn || !r.mrstSync)
      (refreshTrigger && rfshOn && !selfKind) |=> r.rfshPend;
   endproperty
   a_trig: assert property (p_trig) else $error("refresh trigger lost");

   property p_off;
      @(posedge mclk) disable iff (!resetn || !r.mrstSync)
      (r.seq == SQ_IDLE && !rfshOn) |=> r.seq != SQ_CBR_CAS;
   endproperty
   a_off: assert property (p_off) else $error("refresh while disabled");

   property p_forget;
      @(posedge mclk) disable iff (!resetn)
      nonDramAccess |=> !r.rowValid;
   endproperty
   a_forget: assert property (p_forget) else $error("row kept after foreign access");

   c_self: cover property (@(posedge mclk) r.seq == SQ_SELF);
   c_hit: cover property (@(posedge mclk) r.seq == SQ_HOLD && n.seq == SQ_COL);
   c_wait: cover property (@(posedge mclk) r.seq == SQ_CBR_WAIT);
   c_prech2: cover property (@(posedge mclk) prechRun == 7'(PRE2 - 1));
endmodule

// ===== hdl/dac_pkg.sv
// Purpose: shared constants and types of the dram area control block
// Assumes: apb with 32-bit data, 16-bit registers in the low half
// Notes: one dram state lasts DAC_STATE_TICKS system clocks
package dac_pkg;
   // register byte addresses
   localparam logic [11:0] DAC_OFF_DRAM = 12'h000;
   localparam logic [11:0] DAC_OFF_RFSH = 12'h004;
   localparam logic [11:0] DAC_OFF_STAT = 12'h008;
   // dram_area_ctrl_reg fields
   localparam int DAC_DUALWE = 15;
   localparam int DAC_HOLDLOW = 14;
   localparam int DAC_PRECH2 = 13;
   localparam int DAC_BURST = 12;
   localparam int DAC_DUTY35 = 11;
   localparam int DAC_MUXEN = 10;
   localparam int DAC_SHIFT = 8;
   // refresh_ctrl_reg fields
   localparam int DAC_RFEN = 7;
   localparam int DAC_RFKIND = 6;
   localparam int DAC_RFWAIT = 4;
   // reset values, writable masks, write key
   localparam logic [15:0] DAC_DRAM_RST = 16'h0000;
   localparam logic [15:0] DAC_RFSH_RST = 16'h0000;
   localparam logic [15:0] DAC_DRAM_WMASK = 16'hff00;
   localparam logic [15:0] DAC_RFSH_WMASK = 16'h00f0;
   localparam logic [7:0] DAC_RFSH_KEY = 8'h5a;
   // state timing in system clocks
   localparam int DAC_CNT_W = 5;
   localparam int DAC_STATE_TICKS = 20;
   localparam logic [4:0] DAC_HIGH50 = 5'(DAC_STATE_TICKS * 50 / 100);
   localparam logic [4:0] DAC_HIGH35 = 5'(DAC_STATE_TICKS * 35 / 100);
   localparam int DAC_ADDR_W = 28;

   typedef enum logic [3:0] {
      SQ_IDLE, SQ_ROW, SQ_COL, SQ_HOLD, SQ_PRECH,
      SQ_CBR_CAS, SQ_CBR_RAS, SQ_CBR_WAIT, SQ_SELF
   } dac_seq_type;

   typedef struct packed {
      logic req;
      logic [DAC_ADDR_W-1:0] addr;
      logic write;
      logic wide;
      logic hiByte;
      logic loByte;
   } dac_acc_type;

   typedef struct packed {
      logic rasN;
      logic upperColN;
      logic lowerColN;
      logic upperWrN;
      logic lowerWrN;
      logic [DAC_ADDR_W-1:0] addr;
   } dac_pins_type;

   localparam dac_pins_type DAC_PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '0};

   typedef struct packed {
      logic [DAC_CNT_W-1:0] cnt;
   } dac_tmr_type;

   typedef struct packed {
      logic [15:0] dramCtrl;
      logic [15:0] rfshCtrl;
      logic [15:0] rdData;
      dac_seq_type seq;
      logic prechLeft;
      logic [2:0] waitLeft;
      logic rfshPend;
      logic selfOn;
      logic rowValid;
      logic [DAC_ADDR_W-1:0] lastRow;
      dac_acc_type cur;
      logic mrstMeta;
      logic mrstSync;
      logic waitMeta;
      logic waitSync;
      logic done;
      dac_pins_type pins;
   } dac_state_type;
endpackage

// ===== hdl/dac_state_timer.sv
// Purpose: counts the system clocks of one dram state
// Assumes: run stays high across back-to-back states
// Notes: count returns to zero whenever run is low
`timescale 1ns/10ps
module dac_state_timer
   import dac_pkg::*;
#(
   parameter int TICKS = DAC_STATE_TICKS
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // control
   input wire logic run,
   // status
   output logic [DAC_CNT_W-1:0] phase,
   output logic stateEnd
);
   localparam logic [DAC_CNT_W-1:0] LAST = DAC_CNT_W'(TICKS - 1);

   dac_tmr_type r;
   dac_tmr_type n;

   always_comb
   begin
      n = r;
      stateEnd = run && (r.cnt == LAST);
      if (!run || stateEnd)
      begin
         n.cnt = '0;
      end
      else
      begin
         n.cnt = r.cnt + 1'b1;
      end
      phase = r.cnt;
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         r <= '0;
      end
      else
      begin
         r <= n;
      end
   end
endmodule

// ===== tb/dac_dram_model.sv
// Purpose: stand-in for the dram devices on the memory bus
// Assumes: strobes active low, looked at on each rising mclk edge
// Notes: counts strobe falls only; wait pin rests at its pull-up
`timescale 1ns/10ps
module dac_dram_model
   import dac_pkg::*;
(
   // clock
   input wire logic mclk,
   // dram pins
   input dac_pins_type pins,
   output logic waitN,
   // event counts
   output int rasFalls,
   output int cbrFalls,
   output int upColFalls,
   output int upWrFalls
);
   dac_pins_type prev_r = DAC_PINS_IDLE;
   // devices never stretch a cycle
   assign waitN = 1'b1;
   initial
   begin
      rasFalls = 0;
      cbrFalls = 0;
      upColFalls = 0;
      upWrFalls = 0;
   end
   always @(posedge mclk)
   begin
      prev_r <= pins;
      if (prev_r.rasN && !pins.rasN)
      begin
         rasFalls <= rasFalls + 1;
         // column strobe already low marks a cbr refresh
         if (!pins.lowerColN)
         begin
            cbrFalls <= cbrFalls + 1;
         end
      end
      if (prev_r.upperColN && !pins.upperColN)
      begin
         upColFalls <= upColFalls + 1;
      end
      if (prev_r.upperWrN && !pins.upperWrN)
      begin
         upWrFalls <= upWrFalls + 1;
      end
   end
endmodule

// ===== tb/dram_area_and_refresh_control_test.sv
// Purpose: self-checking bench of the dram area and refresh control
// Assumes: apb slave answers with zero wait states
// Notes: strobe activity judged by the dram model's counters
`timescale 1ns/10ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module dram_area_and_refresh_control_test
   import dac_pkg::*;
;
   typedef struct packed {logic [11:0] a; logic [31:0] d; logic [3:0] s; logic [15:0] e;} dac_row_type;
   typedef struct packed {logic [15:0] c; logic w; int r; int u; int v;} dac_arow_type;
   logic mclk = 0, resetn = 0, manualResetn = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdq;
   logic [3:0] pstrb = '0;
   logic pready, pslverr, slvErr, accAck, accDone, waitN, selfRefreshOn, ok;
   logic dramSpaceEnable = 0, refreshWaitEnable = 0, refreshTrigger = 0, nonDramAccess = 0;
   dac_acc_type acc = '0;
   dac_pins_type pins;
   int errors = 0, nTests = 0, cycles = 0, rasFalls, cbrFalls, upColFalls, upWrFalls, r0, c0, u0, w0;
   dac_row_type rows [6] = '{
      '{DAC_OFF_DRAM, 32'h0000ffff, 4'h3, 16'hff00}, '{DAC_OFF_DRAM, 32'h0, 4'h3, 16'h0000},
      '{DAC_OFF_RFSH, 32'h00005aff, 4'h3, 16'h00f0}, '{DAC_OFF_RFSH, 32'h000000a0, 4'h3, 16'h00f0},
      '{DAC_OFF_RFSH, 32'h00005a30, 4'h1, 16'h00f0}, '{DAC_OFF_RFSH, 32'h00005a00, 4'h3, 16'h0000}};
   dac_arow_type arows [4] = '{'{16'h0d00, 1, 1, 1, 0}, '{16'ha000, 1, 1, 0, 1},
      '{16'h8000, 0, 1, 0, 0}, '{16'h0000, 0, 1, 0, 0}};
   always #50 mclk = ~mclk;
   dac_dram_ctrl dut_u (.mclk(mclk), .resetn(resetn), .manualResetn(manualResetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dramSpaceEnable(dramSpaceEnable), .refreshWaitEnable(refreshWaitEnable),
      .refreshTrigger(refreshTrigger), .nonDramAccess(nonDramAccess), .acc(acc),
      .accAck(accAck), .accDone(accDone), .waitN(waitN), .pins(pins),
      .selfRefreshOn(selfRefreshOn));
   dac_dram_model model_u (.mclk(mclk), .pins(pins), .waitN(waitN), .rasFalls(rasFalls),
      .cbrFalls(cbrFalls), .upColFalls(upColFalls), .upWrFalls(upWrFalls));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("tests %0d errors %0d", nTests, errors);
      if (errors == 0 && nTests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         errors++;
         give_verdict();
      end
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
      @(posedge mclk);
      penable <= 1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdq = prdata;
      slvErr = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic access(input logic wide, input logic [27:0] a);
      int n;
      @(posedge mclk);
      acc <= '{1'b1, a, 1'b1, wide, 1'b1, 1'b1};
      for (n = 0; n < 60 && accAck !== 1'b1; n++) @(posedge mclk);
      acc.req <= 1'b0;
      for (n = 0; n < 100 && accDone !== 1'b1; n++) @(posedge mclk);
      ok = accDone;
   endtask
   task automatic trig();
      @(posedge mclk);
      refreshTrigger <= 1;
      @(posedge mclk);
      refreshTrigger <= 0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge mclk);
      resetn <= 1;
      repeat (3) @(posedge mclk);
      apb(0, DAC_OFF_DRAM, 0, 0);
      `CHK(rdq, 32'h0)
      apb(0, DAC_OFF_RFSH, 0, 0);
      `CHK(rdq, 32'h0)
      // keyed writes, reserved bits
      foreach (rows[i])
      begin
         apb(1, rows[i].a, rows[i].d, rows[i].s);
         apb(0, rows[i].a, 0, 0);
         `CHK(rdq, {16'h0, rows[i].e})
      end
      apb(0, 12'h00c, 0, 0);
      `CHK(slvErr, 1'b1)
      access(1, 28'h0);
      `CHK(ok, 1'b0)
      dramSpaceEnable <= 1;
      // strobe method per width
      foreach (arows[i])
      begin
         apb(1, DAC_OFF_DRAM, {16'h0, arows[i].c}, 4'h3);
         {r0, u0, w0} = {rasFalls, upColFalls, upWrFalls};
         access(arows[i].w, 28'h0123456);
         repeat (60) @(posedge mclk);
         `CHK(rasFalls - r0, arows[i].r)
         `CHK(upColFalls - u0, arows[i].u)
         `CHK(upWrFalls - w0, arows[i].v)
      end
      // row strobe held low, so a page hit can follow the pause
      apb(1, DAC_OFF_DRAM, 32'h5000, 4'h3);
      r0 = rasFalls;
      access(1, 28'h0123456);
      access(1, 28'h01234ff);
      repeat (60) @(posedge mclk);
      `CHK(rasFalls - r0, 1)
      @(posedge mclk);
      nonDramAccess <= 1;
      @(posedge mclk);
      nonDramAccess <= 0;
      access(1, 28'h0123456);
      repeat (60) @(posedge mclk);
      `CHK(rasFalls - r0, 2)
      manualResetn <= 0;
      repeat (5) @(posedge mclk);
      manualResetn <= 1;
      apb(0, DAC_OFF_DRAM, 0, 0);
      `CHK(rdq, 32'h5000)
      // cbr refresh with four waits
      refreshWaitEnable <= 1;
      apb(1, DAC_OFF_RFSH, 32'h5ab0, 4'h3);
      c0 = cbrFalls;
      trig();
      repeat (70) @(posedge mclk);
      apb(0, DAC_OFF_STAT, 0, 0);
      `CHK(rdq, {28'h0, SQ_CBR_WAIT})
      repeat (230) @(posedge mclk);
      `CHK(cbrFalls - c0, 1)
      apb(1, DAC_OFF_RFSH, 32'h5a40, 4'h3);
      trig();
      repeat (200) @(posedge mclk);
      `CHK(cbrFalls - c0, 1)
      `CHK(selfRefreshOn, 1'b0)
      // cbr refresh with waits disabled
      refreshWaitEnable <= 0;
      apb(1, DAC_OFF_RFSH, 32'h5ab0, 4'h3);
      trig();
      repeat (70) @(posedge mclk);
      apb(0, DAC_OFF_STAT, 0, 0);
      `CHK(rdq, {28'h0, SQ_IDLE})
      apb(1, DAC_OFF_RFSH, 32'h5ac0, 4'h3);
      repeat (100) @(posedge mclk);
      `CHK(selfRefreshOn, 1'b1)
      // leave self-refresh keeping enable
      apb(1, DAC_OFF_RFSH, 32'h5a80, 4'h3);
      repeat (150) @(posedge mclk);
      `CHK(selfRefreshOn, 1'b0)
      give_verdict();
   end
endmodule
